// ### pkg/bkpsw_pkg.sv
// Package with register map, field positions and reset values of the backup power switch block.
package bkpsw_pkg;

  // ==========================================================================
  // Register byte offsets on the APB window.
  // ==========================================================================
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] COMP_CFG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS   = 8'h08;
  localparam logic [7:0] PD_LO_OFS    = 8'h0c;
  localparam logic [7:0] PD_HI_OFS    = 8'h10;
  localparam logic [7:0] PU_LO_OFS    = 8'h14;
  localparam logic [7:0] PU_HI_OFS    = 8'h18;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int CTRL_CLR_BIT     = 0;
  localparam int CTRL_BOSEL_LSB   = 1;
  localparam int CTRL_BOSEL_W     = 3;
  localparam int CFG_TSE_BIT      = 0;
  localparam int CFG_BACKUP_TEMP_SENSE_EN_BIT     = 1;
  localparam int CFG_IOBK_BIT     = 2;
  localparam int ST_CLKFAIL_BIT   = 0;
  localparam int ST_BATLOW2_BIT   = 1;
  localparam int ST_BATLOW1_BIT   = 2;
  localparam int ST_BROWNOUT_BIT  = 3;
  localparam int ST_BACKUP_BIT    = 4;
  localparam int ST_PDVALID_BIT   = 5;

  // ==========================================================================
  // Sizes and reset values.
  // ==========================================================================
  localparam int          STAMP_W       = 40;
  localparam int          BO_LEVELS     = 6;
  localparam int          CMP_W         = 11;
  localparam logic [2:0]  BOSEL_RST     = 3'h0;
  localparam logic [2:0]  BOSEL_MAX     = 3'h5;
  localparam logic [2:0]  CFG_RST       = 3'h4;
  localparam logic [39:0] STAMP_RST     = 40'h00_0000_0000;

  typedef enum logic {BKPSW_MAIN, BKPSW_BACKUP} bkpsw_mode_e;

endpackage

// ### core/bkpsw_sync.sv
// Two-stage synchroniser for a group of asynchronous comparator levels.
`timescale 1ns/1ps
module bkpsw_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,    // Block clock.
  input  wire logic         presetn, // Asynchronous reset, active low.
  input  wire logic [W-1:0] async_i, // Levels from another domain.
  output logic      [W-1:0] sync_o   // Levels safe to use on pclk.
);

  // ==========================================================================
  // One pair of flip-flops per bit; the first stage feeds only the second.
  // ==========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_q;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q    <= 1'b0;
          sync_o[gi] <= 1'b0;
        end else begin
          meta_q    <= async_i[gi];
          sync_o[gi] <= meta_q;
        end
      end
    end
  endgenerate

endmodule // bkpsw_sync

// ### core/bkpsw_stamp.sv
// Time-stamp holding register with capture, clear and keep-first option.
`timescale 1ns/1ps
module bkpsw_stamp #(
  parameter bit KEEP_FIRST = 1'b0
) (
  input  wire logic                        pclk,     // Block clock.
  input  wire logic                        presetn,  // Asynchronous reset, active low.
  input  wire logic                        capture,  // Switchover event, one cycle.
  input  wire logic                        clear,    // Software clear, one cycle.
  input  wire logic [bkpsw_pkg::STAMP_W-1:0] time_now, // Current time and date.
  output logic      [bkpsw_pkg::STAMP_W-1:0] stamp_q,  // Held stamp.
  output logic                             valid_q   // Stamp holds a capture.
);

  logic take;

  // A held first capture blocks later ones until the clear.
  assign take = capture && !(KEEP_FIRST && valid_q && !clear);

  // ==========================================================================
  // Capture wins over a clear arriving in the same cycle.
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_q <= bkpsw_pkg::STAMP_RST;
      valid_q <= 1'b0;
    end else if (take) begin
      stamp_q <= time_now;
      valid_q <= 1'b1;
    end else if (clear) begin
      stamp_q <= bkpsw_pkg::STAMP_RST;
      valid_q <= 1'b0;
    end
  end

endmodule // bkpsw_stamp

// ### core/bkpsw_top.sv
// Supply mode control, switchover time stamps and power status flags.
//
// Functional notes
// - Enter backup only when main is below backup minus hysteresis and below trip.
// - Return to main when above backup plus hysteresis or above trip plus 30mV.
// - Serial host interface is disabled throughout backup mode.
// - Other functions and IO keep running in backup unless a control bit disables.
// - Main-to-backup switch stamps time; only the first stamp is kept until clear.
// - Backup-to-main switch stamps time, always overwriting with the latest.
// - Power-down stamp holds until software writes 1 to stamp_clear.
// - Temperature conversion runs in backup only with backup_temp_sense_en set.
// - clock_fail_flag reports power-up after loss of both supplies.
// - Six selectable brownout levels; brownout_flag set when main drops below.
// - Brownout alone never disables the serial interface.
// - Battery between 85% and 75% sets first low flag; below 75% sets both.
// - No battery monitoring in backup; software sets temp_sense_en to measure.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
module bkpsw_top (
  input  wire logic        pclk,             // APB and block clock, 40 MHz.
  input  wire logic        presetn,          // Asynchronous reset, active low.
  input  wire logic        psel,             // APB select.
  input  wire logic        penable,          // APB enable.
  input  wire logic        pwrite,           // APB write.
  input  wire logic [7:0]  paddr,            // APB byte address.
  input  wire logic [31:0] pwdata,           // APB write data.
  output logic      [31:0] prdata,           // APB read data.
  output logic             pready,           // APB ready.
  output logic             pslverr,          // APB error on unmapped address.
  input  wire logic        cmp_enter_bat,    // Main at or below backup minus hysteresis.
  input  wire logic        cmp_below_trip,   // Main below switch_trip_level.
  input  wire logic        cmp_above_bat,    // Main above backup plus hysteresis.
  input  wire logic        cmp_above_trip,   // Main above trip plus trip_hysteresis.
  input  wire logic [5:0]  cmp_brownout,     // Main below each brownout level.
  input  wire logic        cmp_bat_low85,    // Backup below 85 percent.
  input  wire logic        cmp_bat_low75,    // Backup below 75 percent.
  input  wire logic        total_loss,       // High after power-up from loss of both supplies.
  input  wire logic [39:0] time_now,         // Current time and date from calendar.
  output logic             serial_if_en,     // Serial host interface enable.
  output logic             backup_mode,      // High while on backup supply.
  output logic             temp_conv_en,     // Temperature conversion enable.
  output logic             aux_io_en,        // Alarm and frequency output enable.
  output logic             batt_meas_en      // Battery level measurement running.
);

  // ==========================================================================
  // Synchronised comparator levels.
  // ==========================================================================
  logic [bkpsw_pkg::CMP_W-1:0] cmp_async;
  logic [bkpsw_pkg::CMP_W-1:0] cmp_sync;
  logic                        s_enter_bat;
  logic                        s_below_trip;
  logic                        s_above_bat;
  logic                        s_above_trip;
  logic [5:0]                  s_brownout;
  logic                        s_low85;
  logic                        s_low75;

  assign cmp_async = {total_loss, cmp_bat_low75, cmp_bat_low85, cmp_brownout,
                      cmp_above_trip, cmp_above_bat};

  bkpsw_sync #(.W(bkpsw_pkg::CMP_W)) u_sync_a (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i (cmp_async),
    .sync_o  (cmp_sync)
  );

  logic [1:0] entry_sync;

  bkpsw_sync #(.W(2)) u_sync_b (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i ({cmp_below_trip, cmp_enter_bat}),
    .sync_o  (entry_sync)
  );

  logic s_total_loss;

  assign s_enter_bat  = entry_sync[0];
  assign s_below_trip = entry_sync[1];
  assign s_above_bat  = cmp_sync[0];
  assign s_above_trip = cmp_sync[1];
  assign s_brownout   = cmp_sync[7:2];
  assign s_low85      = cmp_sync[8];
  assign s_low75      = cmp_sync[9];
  assign s_total_loss = cmp_sync[10];

  // ==========================================================================
  // Control registers.
  // ==========================================================================
  logic       wr_en;
  logic       rd_setup;
  logic [2:0] bo_sel_q;
  logic       tse_q;
  logic       backup_temp_sense_en_q;
  logic       io_bk_q;
  logic       stamp_clear;

  assign wr_en    = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable;

  assign stamp_clear = wr_en && (paddr == bkpsw_pkg::CTRL_OFS)
                       && pwdata[bkpsw_pkg::CTRL_CLR_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bo_sel_q <= bkpsw_pkg::BOSEL_RST;
    end else if (wr_en && paddr == bkpsw_pkg::CTRL_OFS) begin
      if (pwdata[bkpsw_pkg::CTRL_BOSEL_LSB +: bkpsw_pkg::CTRL_BOSEL_W] > bkpsw_pkg::BOSEL_MAX) begin
        bo_sel_q <= bkpsw_pkg::BOSEL_MAX;
      end else begin
        bo_sel_q <= pwdata[bkpsw_pkg::CTRL_BOSEL_LSB +: bkpsw_pkg::CTRL_BOSEL_W];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tse_q   <= bkpsw_pkg::CFG_RST[bkpsw_pkg::CFG_TSE_BIT];
      backup_temp_sense_en_q  <= bkpsw_pkg::CFG_RST[bkpsw_pkg::CFG_BACKUP_TEMP_SENSE_EN_BIT];
      io_bk_q <= bkpsw_pkg::CFG_RST[bkpsw_pkg::CFG_IOBK_BIT];
    end else if (wr_en && paddr == bkpsw_pkg::COMP_CFG_OFS) begin
      tse_q   <= pwdata[bkpsw_pkg::CFG_TSE_BIT];
      backup_temp_sense_en_q  <= pwdata[bkpsw_pkg::CFG_BACKUP_TEMP_SENSE_EN_BIT];
      io_bk_q <= pwdata[bkpsw_pkg::CFG_IOBK_BIT];
    end
  end

  // ==========================================================================
  // Supply mode state machine.
  // ==========================================================================
  bkpsw_pkg::bkpsw_mode_e mode_q;
  bkpsw_pkg::bkpsw_mode_e mode_d;
  logic                   to_backup;
  logic                   to_main;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      bkpsw_pkg::BKPSW_MAIN: begin
        if (s_enter_bat && s_below_trip) begin
          mode_d = bkpsw_pkg::BKPSW_BACKUP;
        end
      end
      bkpsw_pkg::BKPSW_BACKUP: begin
        if (s_above_bat || s_above_trip) begin
          mode_d = bkpsw_pkg::BKPSW_MAIN;
        end
      end
      default: mode_d = bkpsw_pkg::BKPSW_MAIN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= bkpsw_pkg::BKPSW_MAIN;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign to_backup = (mode_q == bkpsw_pkg::BKPSW_MAIN) && (mode_d == bkpsw_pkg::BKPSW_BACKUP);
  assign to_main   = (mode_q == bkpsw_pkg::BKPSW_BACKUP) && (mode_d == bkpsw_pkg::BKPSW_MAIN);

  // ==========================================================================
  // Enables driven out of the block.
  // ==========================================================================
  logic in_backup_d;

  assign in_backup_d = (mode_d == bkpsw_pkg::BKPSW_BACKUP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_if_en <= 1'b1;
      backup_mode  <= 1'b0;
      temp_conv_en <= 1'b0;
      aux_io_en    <= 1'b1;
      batt_meas_en <= 1'b0;
    end else begin
      serial_if_en <= !in_backup_d;
      backup_mode  <= in_backup_d;
      temp_conv_en <= in_backup_d ? backup_temp_sense_en_q : tse_q;
      aux_io_en    <= !in_backup_d || io_bk_q;
      batt_meas_en <= !in_backup_d && tse_q;
    end
  end

  // ==========================================================================
  // Switchover time stamps.
  // ==========================================================================
  logic [39:0] pd_stamp_q;
  logic [39:0] pu_stamp_q;
  logic        pd_valid_q;

  bkpsw_stamp #(.KEEP_FIRST(1'b1)) u_powerdown_stamp (
    .pclk     (pclk),
    .presetn  (presetn),
    .capture  (to_backup),
    .clear    (stamp_clear),
    .time_now (time_now),
    .stamp_q  (pd_stamp_q),
    .valid_q  (pd_valid_q)
  );

  bkpsw_stamp #(.KEEP_FIRST(1'b0)) u_powerup_stamp (
    .pclk     (pclk),
    .presetn  (presetn),
    .capture  (to_main),
    .clear    (stamp_clear),
    .time_now (time_now),
    .stamp_q  (pu_stamp_q),
    .valid_q  ()
  );

  // ==========================================================================
  // Status flags; hardware set wins over a software clear.
  // ==========================================================================
  logic clock_fail_flag_q;
  logic brownout_flag_q;
  logic battery_low_first_q;
  logic battery_low_second_q;
  logic st_clr_wr;
  logic loss_seen_q;

  assign st_clr_wr = wr_en && (paddr == bkpsw_pkg::STATUS_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loss_seen_q <= 1'b0;
    end else begin
      loss_seen_q <= s_total_loss;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_fail_flag_q <= 1'b0;
    end else if (s_total_loss && !loss_seen_q) begin
      clock_fail_flag_q <= 1'b1;
    end else if (st_clr_wr && pwdata[bkpsw_pkg::ST_CLKFAIL_BIT]) begin
      clock_fail_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_flag_q <= 1'b0;
    end else if (s_brownout[bo_sel_q]) begin
      brownout_flag_q <= 1'b1;
    end else if (st_clr_wr && pwdata[bkpsw_pkg::ST_BROWNOUT_BIT]) begin
      brownout_flag_q <= 1'b0;
    end
  end

  // Battery flags follow the comparators only while a measurement runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      battery_low_first_q  <= 1'b0;
      battery_low_second_q <= 1'b0;
    end else if (batt_meas_en) begin
      battery_low_first_q  <= s_low85 || s_low75;
      battery_low_second_q <= s_low75;
    end
  end

  // ==========================================================================
  // APB slave: data registered in setup, zero wait states.
  // ==========================================================================
  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      bkpsw_pkg::CTRL_OFS: begin
        rd_mux[bkpsw_pkg::CTRL_BOSEL_LSB +: bkpsw_pkg::CTRL_BOSEL_W] = bo_sel_q;
      end
      bkpsw_pkg::COMP_CFG_OFS: begin
        rd_mux[bkpsw_pkg::CFG_TSE_BIT]  = tse_q;
        rd_mux[bkpsw_pkg::CFG_BACKUP_TEMP_SENSE_EN_BIT] = backup_temp_sense_en_q;
        rd_mux[bkpsw_pkg::CFG_IOBK_BIT] = io_bk_q;
      end
      bkpsw_pkg::STATUS_OFS: begin
        rd_mux[bkpsw_pkg::ST_CLKFAIL_BIT]  = clock_fail_flag_q;
        rd_mux[bkpsw_pkg::ST_BATLOW2_BIT]  = battery_low_second_q;
        rd_mux[bkpsw_pkg::ST_BATLOW1_BIT]  = battery_low_first_q;
        rd_mux[bkpsw_pkg::ST_BROWNOUT_BIT] = brownout_flag_q;
        rd_mux[bkpsw_pkg::ST_BACKUP_BIT]   = (mode_q == bkpsw_pkg::BKPSW_BACKUP);
        rd_mux[bkpsw_pkg::ST_PDVALID_BIT]  = pd_valid_q;
      end
      bkpsw_pkg::PD_LO_OFS: rd_mux        = pd_stamp_q[31:0];
      bkpsw_pkg::PD_HI_OFS: rd_mux[7:0]   = pd_stamp_q[39:32];
      bkpsw_pkg::PU_LO_OFS: rd_mux        = pu_stamp_q[31:0];
      bkpsw_pkg::PU_HI_OFS: rd_mux[7:0]   = pu_stamp_q[39:32];
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup && !rd_hit;
      if (rd_setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule // bkpsw_top

// ### test/bkpsw_top_asserts.sv
// Concurrent checks on the ports of the backup power switch top.
`timescale 1ns/1ps
module bkpsw_top_asserts (
  input wire logic pclk,           // Block clock.
  input wire logic presetn,        // Asynchronous reset, active low.
  input wire logic psel,           // APB select.
  input wire logic penable,        // APB enable.
  input wire logic pready,         // APB ready.
  input wire logic cmp_enter_bat,  // Main at or below backup minus hysteresis.
  input wire logic cmp_below_trip, // Main below trip level.
  input wire logic cmp_above_bat,  // Main above backup plus hysteresis.
  input wire logic cmp_above_trip, // Main above trip plus hysteresis.
  input wire logic serial_if_en,   // Serial host interface enable.
  input wire logic backup_mode,    // High on backup supply.
  input wire logic aux_io_en,      // Alarm and frequency output enable.
  input wire logic batt_meas_en    // Battery measurement running.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Mode switching, two sync stages plus the state flop.
  // ==========================================================================
  property p_entry_cause;
    $rose(backup_mode) |-> $past(cmp_enter_bat && cmp_below_trip, 3);
  endproperty
  a_entry_cause: assert property (p_entry_cause) else $error("backup entered without cause");
  property p_exit_cause;
    $fell(backup_mode) |-> $past(cmp_above_bat || cmp_above_trip, 3);
  endproperty
  a_exit_cause: assert property (p_exit_cause) else $error("backup left without cause");
  property p_entry_time;
    (!backup_mode && cmp_enter_bat && cmp_below_trip && !cmp_above_bat && !cmp_above_trip) [*3]
      |=> backup_mode;
  endproperty
  a_entry_time: assert property (p_entry_time) else $error("backup entry late");
  property p_exit_time;
    (backup_mode && (cmp_above_bat || cmp_above_trip)) [*3] |=> !backup_mode;
  endproperty
  a_exit_time: assert property (p_exit_time) else $error("backup exit late");
  // ==========================================================================
  // Outputs that follow the mode.
  // ==========================================================================
  property p_serial;
    serial_if_en != backup_mode;
  endproperty
  a_serial: assert property (p_serial) else $error("serial enable wrong for mode");
  property p_aux;
    !backup_mode [*2] |-> aux_io_en;
  endproperty
  a_aux: assert property (p_aux) else $error("aux io off in main mode");
  property p_batt;
    backup_mode [*2] |-> !batt_meas_en;
  endproperty
  a_batt: assert property (p_batt) else $error("battery measured in backup");
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
endmodule // bkpsw_top_asserts

// ### test/bkpsw_supply_model.sv
// Behavioural supply comparators driven from millivolt levels.
`timescale 1ns/1ps
module bkpsw_supply_model #(
  parameter int HYS_MV      = 50,
  parameter int TRIP_MV     = 2200,
  parameter int TRIP_HYS_MV = 30,
  parameter int BAT_NOM_MV  = 3000,
  parameter int BO_MV [6]   = '{4250, 2805, 2550, 2295, 2125, 1530}
) (
  input  wire logic [15:0] vdd_mv,         // Main supply level.
  input  wire logic [15:0] vbat_mv,        // Backup supply level.
  output logic             cmp_enter_bat,  // Main at or below backup minus hysteresis.
  output logic             cmp_below_trip, // Main below trip level.
  output logic             cmp_above_bat,  // Main above backup plus hysteresis.
  output logic             cmp_above_trip, // Main above trip plus hysteresis.
  output logic [5:0]       cmp_brownout,   // Main below each brownout level.
  output logic             cmp_bat_low85,  // Backup below 85 percent.
  output logic             cmp_bat_low75   // Backup below 75 percent.
);
  assign cmp_enter_bat  = (int'(vdd_mv) + HYS_MV) <= int'(vbat_mv);
  assign cmp_below_trip = int'(vdd_mv) < TRIP_MV;
  assign cmp_above_bat  = int'(vdd_mv) > (int'(vbat_mv) + HYS_MV);
  assign cmp_above_trip = int'(vdd_mv) > (TRIP_MV + TRIP_HYS_MV);
  assign cmp_bat_low85  = (int'(vbat_mv) * 100) < (BAT_NOM_MV * 85);
  assign cmp_bat_low75  = (int'(vbat_mv) * 100) < (BAT_NOM_MV * 75);
  for (genvar i = 0; i < 6; i++) begin : g_bo
    assign cmp_brownout[i] = int'(vdd_mv) < BO_MV[i];
  end
endmodule // bkpsw_supply_model

// ### test/testbench.sv
// Self-checking bench for the backup power switch block.
`timescale 1ns/1ps
module testbench;
  localparam int BO_MV [6] = '{4250, 2805, 2550, 2295, 2125, 1530};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, total_loss;
  logic        cmp_enter_bat, cmp_below_trip, cmp_above_bat, cmp_above_trip;
  logic        cmp_bat_low85, cmp_bat_low75, serial_if_en, backup_mode;
  logic        temp_conv_en, aux_io_en, batt_meas_en;
  logic [5:0]  cmp_brownout;
  logic [7:0]  paddr;
  logic [15:0] vdd_mv, vbat_mv;
  logic [31:0] pwdata, prdata, rd;
  logic [39:0] time_now;
  int          bad_count, n_checks;

  bkpsw_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_enter_bat(cmp_enter_bat), .cmp_below_trip(cmp_below_trip),
    .cmp_above_bat(cmp_above_bat), .cmp_above_trip(cmp_above_trip),
    .cmp_brownout(cmp_brownout), .cmp_bat_low85(cmp_bat_low85),
    .cmp_bat_low75(cmp_bat_low75), .total_loss(total_loss), .time_now(time_now),
    .serial_if_en(serial_if_en), .backup_mode(backup_mode), .temp_conv_en(temp_conv_en),
    .aux_io_en(aux_io_en), .batt_meas_en(batt_meas_en));
  bkpsw_supply_model #(.BO_MV(BO_MV)) sup_u (.vdd_mv(vdd_mv), .vbat_mv(vbat_mv),
    .cmp_enter_bat(cmp_enter_bat), .cmp_below_trip(cmp_below_trip),
    .cmp_above_bat(cmp_above_bat), .cmp_above_trip(cmp_above_trip),
    .cmp_brownout(cmp_brownout), .cmp_bat_low85(cmp_bat_low85),
    .cmp_bat_low75(cmp_bat_low75));

  // ==========================================================================
  // Bus and comparison tasks.
  // ==========================================================================
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  // Moves the supplies and lets the sync stages and the mode flop settle.
  task automatic setv(input int vdd, input int vbat, input logic [39:0] t);
    @(posedge pclk);
    vdd_mv <= 16'(vdd);
    vbat_mv <= 16'(vbat);
    time_now <= t;
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    bad_count++;
    conclude();
  end

  // ==========================================================================
  // Tests.
  // ==========================================================================
  initial begin
    {presetn, psel, penable, pwrite, total_loss} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    vdd_mv = 16'd5000;
    vbat_mv = 16'd3000;
    time_now = 40'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl", bkpsw_pkg::CTRL_OFS, 32'h0);
    rdchk("comp_cfg", bkpsw_pkg::COMP_CFG_OFS, 32'h4);
    rdchk("status", bkpsw_pkg::STATUS_OFS, 32'h0);
    rdchk("pd_lo", bkpsw_pkg::PD_LO_OFS, 32'h0);
    rdchk("unmapped", 8'h1c, 32'h0);
    chk("pslverr", {31'h0, serr}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, bkpsw_pkg::CTRL_OFS, 32'(i) << 1);
      setv(BO_MV[i] + 10, 1400, 40'h0);
      xfer(1'b1, bkpsw_pkg::STATUS_OFS, 32'h8);
      rdchk("brownout_above", bkpsw_pkg::STATUS_OFS, 32'h0);
      setv(BO_MV[i] - 10, 1400, 40'h0);
      rdchk("brownout_below", bkpsw_pkg::STATUS_OFS, 32'h8);
      chk("serial_if_en", {31'h0, serial_if_en}, 32'h1);
    end
    xfer(1'b1, bkpsw_pkg::CTRL_OFS, 32'he);
    rdchk("ctrl_clamp", bkpsw_pkg::CTRL_OFS, 32'ha);
    xfer(1'b1, bkpsw_pkg::CTRL_OFS, 32'h0);
    setv(5000, 3000, 40'h0);
    xfer(1'b1, bkpsw_pkg::STATUS_OFS, 32'h8);
    $display("test brownout done");
    xfer(1'b1, bkpsw_pkg::COMP_CFG_OFS, 32'h5);
    setv(5000, 2400, 40'h0);
    rdchk("bat_first", bkpsw_pkg::STATUS_OFS, 32'h4);
    chk("temp_main", {31'h0, temp_conv_en}, 32'h1);
    chk("batt_meas", {31'h0, batt_meas_en}, 32'h1);
    setv(5000, 2000, 40'h0);
    rdchk("bat_both", bkpsw_pkg::STATUS_OFS, 32'h6);
    setv(5000, 3000, 40'h0);
    rdchk("bat_ok", bkpsw_pkg::STATUS_OFS, 32'h0);
    xfer(1'b1, bkpsw_pkg::COMP_CFG_OFS, 32'h5);
    $display("test battery done");
    setv(1500, 3000, 40'ha1_1111_1111);
    chk("enter", {31'h0, backup_mode}, 32'h1);
    chk("serial_off", {31'h0, serial_if_en}, 32'h0);
    setv(1500, 2000, 40'ha1_1111_1111);
    rdchk("status_bk", bkpsw_pkg::STATUS_OFS, 32'h38);
    xfer(1'b1, bkpsw_pkg::COMP_CFG_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    chk("temp_bk_on", {31'h0, temp_conv_en}, 32'h1);
    chk("aux_bk_off", {31'h0, aux_io_en}, 32'h0);
    xfer(1'b1, bkpsw_pkg::COMP_CFG_OFS, 32'h4);
    repeat (2) @(posedge pclk);
    chk("temp_bk_off", {31'h0, temp_conv_en}, 32'h0);
    chk("aux_bk_on", {31'h0, aux_io_en}, 32'h1);
    rdchk("pd_lo1", bkpsw_pkg::PD_LO_OFS, 32'h1111_1111);
    rdchk("pd_hi1", bkpsw_pkg::PD_HI_OFS, 32'ha1);
    setv(5000, 3000, 40'hb2_2222_2222);
    chk("exit_bat", {31'h0, backup_mode}, 32'h0);
    rdchk("pu_lo2", bkpsw_pkg::PU_LO_OFS, 32'h2222_2222);
    setv(1500, 3000, 40'hc3_3333_3333);
    setv(2500, 3000, 40'hd4_4444_4444);
    chk("exit_trip", {31'h0, backup_mode}, 32'h0);
    rdchk("pd_keep", bkpsw_pkg::PD_LO_OFS, 32'h1111_1111);
    rdchk("pu_lo4", bkpsw_pkg::PU_LO_OFS, 32'h4444_4444);
    rdchk("pu_hi4", bkpsw_pkg::PU_HI_OFS, 32'hd4);
    setv(2100, 2000, 40'hd4_4444_4444);
    chk("no_entry", {31'h0, backup_mode}, 32'h0);
    setv(5000, 3000, 40'h0);
    xfer(1'b1, bkpsw_pkg::STATUS_OFS, 32'h8);
    rdchk("status_pd", bkpsw_pkg::STATUS_OFS, 32'h20);
    xfer(1'b1, bkpsw_pkg::CTRL_OFS, 32'h1);
    rdchk("pd_clr", bkpsw_pkg::PD_LO_OFS, 32'h0);
    rdchk("status_clr", bkpsw_pkg::STATUS_OFS, 32'h0);
    $display("test switchover done");
    @(posedge pclk);
    total_loss <= 1'b1;
    repeat (4) @(posedge pclk);
    rdchk("clock_fail", bkpsw_pkg::STATUS_OFS, 32'h1);
    xfer(1'b1, bkpsw_pkg::STATUS_OFS, 32'h1);
    rdchk("clock_fail_clr", bkpsw_pkg::STATUS_OFS, 32'h0);
    $display("test clock fail done");
    conclude();
  end
endmodule // testbench

bind bkpsw_top bkpsw_top_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .cmp_enter_bat(cmp_enter_bat),
  .cmp_below_trip(cmp_below_trip), .cmp_above_bat(cmp_above_bat),
  .cmp_above_trip(cmp_above_trip), .serial_if_en(serial_if_en), .backup_mode(backup_mode),
  .aux_io_en(aux_io_en), .batt_meas_en(batt_meas_en));
